// ### design/arsq_pkg.sv
// shared constants for the asynchronous reset sequencer
package arsq_pkg;
  // clock rate and period
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned CLK_NS = 1000000000 / CLK_HZ;
  // input filter times in ns
  localparam int unsigned FILT_REJECT_NS = 50;
  localparam int unsigned FILT_ACCEPT_NS = 500;
  // accept count rounds down, but the pin must be sampled low 11 times, so a 500 ns pulse is not taken
  localparam int unsigned FILT_CYCLES = (FILT_ACCEPT_NS / CLK_NS) > 0 ?
    (FILT_ACCEPT_NS / CLK_NS) : 1;
  // flash initialisation longest time in us
  localparam int unsigned FLASH_INIT_US = 1000;
  localparam int unsigned FLASH_INIT_CYCLES = (FLASH_INIT_US * (CLK_HZ / 1000000));
  // external boot release delay in half clock periods, 3..8
  localparam int unsigned EXT_HALF_PERIODS_MIN = 3;
  localparam int unsigned EXT_HALF_PERIODS_MAX = 8;
  localparam int unsigned EXT_HALF_PERIODS = EXT_HALF_PERIODS_MAX;
  localparam int unsigned EXT_CYCLES = (EXT_HALF_PERIODS + 1) / 2;
  // flash data answered before initialisation ends
  localparam logic [15:0] FLASH_EARLY_WORD = 16'hFFFF;
  localparam logic [15:0] FLASH_LATE_WORD = 16'h009B;
  // reset vector and code segment
  localparam logic [23:0] RESET_VECTOR = 24'h000000;
  localparam logic [7:0] RESET_SEGMENT = 8'h00;
  // bus widths
  localparam int unsigned BOOT_PORT_W = 16;
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned IO_W = 16;
  // sequencer states, one-hot
  typedef enum logic [4:0] {
    ARSQ_RUN = 5'h01,
    ARSQ_FILTER = 5'h02,
    ARSQ_HELD = 5'h04,
    ARSQ_FLASH = 5'h08,
    ARSQ_EXT = 5'h10
  } arsq_state_e;
endpackage : arsq_pkg

// ### design/arsq_filter.sv
// digital reset input filter with two-flop synchroniser
`timescale 1ns/1ps
module arsq_filter
  import arsq_pkg::*;
#(
  parameter int unsigned CYCLES = FILT_CYCLES
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // raw pin and filtered level
  input wire logic pin_n,
  output logic low_ok,
  output logic raw_low
);
  logic sync1_reg; // first synchroniser stage
  logic sync2_reg; // second synchroniser stage
  logic [15:0] cnt_reg; // cycles the pin has stayed low

  // synchroniser, starts as asserted so a pin held low at power-on gives no false release
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= pin_n;
      sync2_reg <= sync1_reg;
    end
  end

  // count low cycles, short spikes never reach the limit
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      cnt_reg <= 16'h0000;
    else if (sync2_reg)
      cnt_reg <= 16'h0000;
    else if (cnt_reg < 16'(CYCLES))
      cnt_reg <= cnt_reg + 16'h0001;
  end

  // filtered low once the count is full
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      low_ok <= 1'b0;
    else
      low_ok <= !sync2_reg && (cnt_reg >= 16'(CYCLES - 1));
  end

  assign raw_low = !sync2_reg;
endmodule : arsq_filter

// ### design/arsq_top.sv
// asynchronous reset sequencer top
// Behaviour
// [R1] reset-in low with mode low starts reset
// [R2] after filter, default state, reset-out low
// [R3] cancel hold states, abort bus cycles
// [R4] buses and I/O float, boot port pulled
// [R5] system should prefer synchronous reset
// [R6] detection needs no stable clock; here the filter and state machine sample on clk_sys
// [R7] supply holds both pins low at power-on
// [R8] reset-in held 1ms after supply good
// [R9] internal boot waits flash init, max 1ms
// [R10] external boot releases after filter plus 3-8; here EXT lasts EXT_WAIT + 1 cycles, 10 half periods at the default
// [R11] early flash reads give FFFF then 009B
// [R12] power-on low time covers oscillator, PLL
// [R13] reset-in grounded while powering up
// [R14] mode found low or falling while held
// [R15] reset-in low longer than 500ns
// [R16] on release latch boot configuration port
// [R17] address latch, read, write strobes inactive
// [R18] execution starts at vector, segment zero
// [R19] filter rejects spikes, accepts long pulses
// [R20] reset-out low until internal reset released
`timescale 1ns/1ps
module arsq_top
  import arsq_pkg::*;
#(
  parameter int unsigned FLASH_CYCLES = FLASH_INIT_CYCLES,
  parameter int unsigned EXT_WAIT = EXT_CYCLES
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // reset pins
  input wire logic reset_in_n,
  input wire logic reset_mode_select,
  input wire logic external_boot_select,
  output logic reset_out_n,
  // boot configuration port
  input wire logic [BOOT_PORT_W-1:0] boot_config_port_in,
  output logic [BOOT_PORT_W-1:0] boot_config_port_pull,
  output logic boot_pull_en,
  output logic [BOOT_PORT_W-1:0] boot_config,
  // core side
  input wire logic hold_req,
  input wire logic bus_busy,
  output logic core_reset,
  output logic hold_cancel,
  output logic bus_abort,
  output logic [ADDR_W-1:0] start_addr,
  output logic [7:0] start_segment,
  // flash early read answer
  input wire logic flash_read,
  output logic [DATA_W-1:0] flash_rdata,
  output logic flash_ready,
  // pin drivers
  output logic bus_oe,
  output logic io_oe,
  output logic ale,
  output logic rd_n,
  output logic wr_n
);
  arsq_state_e state_reg; // sequencer state
  arsq_state_e state_next; // next state
  logic low_ok; // filtered reset-in low
  logic raw_low; // synchronised reset-in low
  logic mode_s1_reg; // mode pin stage 1
  logic mode_s2_reg; // mode pin stage 2
  logic eboot_s1_reg; // boot select stage 1
  logic eboot_s2_reg; // boot select stage 2
  logic [BOOT_PORT_W-1:0] port_s1_reg; // boot port stage 1
  logic [BOOT_PORT_W-1:0] port_s2_reg; // boot port stage 2
  logic [15:0] wait_reg; // release delay counter
  logic [15:0] flash_cnt_reg; // flash init progress
  logic flash_done_reg; // flash initialised
  logic in_reset; // any reset state

  // reset-in filter
  arsq_filter #(.CYCLES(FILT_CYCLES)) u_filter
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_n(reset_in_n),
    .low_ok(low_ok), // [R19]
    .raw_low(raw_low)
  );

  // synchronise mode, boot select and boot port
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      mode_s1_reg <= 1'b0;
      mode_s2_reg <= 1'b0;
      eboot_s1_reg <= 1'b0;
      eboot_s2_reg <= 1'b0;
      port_s1_reg <= '1;
      port_s2_reg <= '1;
    end
    else
    begin
      mode_s1_reg <= reset_mode_select;
      mode_s2_reg <= mode_s1_reg;
      eboot_s1_reg <= external_boot_select;
      eboot_s2_reg <= eboot_s1_reg;
      port_s1_reg <= boot_config_port_in;
      port_s2_reg <= port_s1_reg;
    end
  end

  assign in_reset = (state_reg != ARSQ_RUN);

  // next state
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ARSQ_RUN:
        // mode found low, or falls later while reset-in held
        if (raw_low && !mode_s2_reg) // [R1] [R14]
          state_next = ARSQ_FILTER;
      ARSQ_FILTER:
        if (!raw_low)
          state_next = ARSQ_RUN; // spike rejected
        else if (low_ok)
          state_next = ARSQ_HELD; // [R2] [R19]
      ARSQ_HELD:
        // once asynchronous, mode pin no longer matters
        if (!raw_low)
          state_next = eboot_s2_reg ? ARSQ_EXT : ARSQ_FLASH; // [R9] [R10]
      ARSQ_FLASH:
        if (raw_low)
          state_next = ARSQ_HELD;
        else if (flash_done_reg)
          state_next = ARSQ_RUN; // [R9] [R16]
      ARSQ_EXT:
        if (raw_low)
          state_next = ARSQ_HELD;
        else if (wait_reg >= 16'(EXT_WAIT))
          state_next = ARSQ_RUN; // [R10]
      default:
        state_next = ARSQ_HELD;
    endcase
  end

  // state register, defaults to held reset at power-on
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      state_reg <= ARSQ_HELD; // [R6]
    else
      state_reg <= state_next;
  end

  // release delay for external boot
  always_ff @(posedge clk_sys)
  begin
    if (rst || state_reg != ARSQ_EXT)
      wait_reg <= 16'h0000;
    else
      wait_reg <= wait_reg + 16'h0001;
  end

  // flash init timer, restarts from each reset-in release
  always_ff @(posedge clk_sys)
  begin
    if (rst || state_reg == ARSQ_HELD)
    begin
      flash_cnt_reg <= 16'h0000;
      flash_done_reg <= 1'b0;
    end
    else if (!flash_done_reg)
    begin
      if (flash_cnt_reg >= 16'(FLASH_CYCLES - 1))
        flash_done_reg <= 1'b1; // [R9]
      else
        flash_cnt_reg <= flash_cnt_reg + 16'h0001;
    end
  end

  // early flash read answer
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      flash_rdata <= FLASH_EARLY_WORD;
      flash_ready <= 1'b0;
    end
    else
    begin
      flash_ready <= flash_done_reg;
      if (flash_read && !flash_done_reg)
        flash_rdata <= (flash_cnt_reg == 16'h0000) ? FLASH_EARLY_WORD : FLASH_LATE_WORD; // [R11]
    end
  end

  // reset output and core reset
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      reset_out_n <= 1'b0;
      core_reset <= 1'b1;
    end
    else
    begin
      reset_out_n <= !(state_next != ARSQ_RUN && state_next != ARSQ_FILTER); // [R2] [R20]
      core_reset <= (state_next != ARSQ_RUN && state_next != ARSQ_FILTER);
    end
  end

  // cancel holds and abort cycles in the held reset state
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      hold_cancel <= 1'b1;
      bus_abort <= 1'b1;
    end
    else
    begin
      hold_cancel <= (state_next == ARSQ_HELD) && hold_req; // [R3]
      bus_abort <= (state_next == ARSQ_HELD) && bus_busy; // [R3]
    end
  end

  // pin drivers float, boot port pulled high, strobes inactive
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      bus_oe <= 1'b0;
      io_oe <= 1'b0;
      boot_pull_en <= 1'b1;
      boot_config_port_pull <= '1;
      ale <= 1'b0;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
    end
    else
    begin
      bus_oe <= (state_next == ARSQ_RUN); // [R4]
      io_oe <= (state_next == ARSQ_RUN); // [R4]
      boot_pull_en <= (state_next != ARSQ_RUN); // [R4]
      boot_config_port_pull <= '1;
      ale <= 1'b0; // [R17]
      rd_n <= 1'b1; // [R17]
      wr_n <= 1'b1; // [R17]
    end
  end

  // latch configuration and vector on exit
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      boot_config <= '1;
      start_addr <= RESET_VECTOR;
      start_segment <= RESET_SEGMENT;
    end
    else if (in_reset && state_next == ARSQ_RUN)
    begin
      boot_config <= port_s2_reg; // [R16]
      start_addr <= RESET_VECTOR; // [R18]
      start_segment <= RESET_SEGMENT; // [R18]
    end
  end
endmodule : arsq_top

// ### tb/arsq_props.sv
// checker for the reset sequencer top
`timescale 1ns/1ps
module arsq_props
  import arsq_pkg::*;
(
  // clock, reset and pins
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reset_in_n,
  input wire logic reset_mode_select,
  input wire logic external_boot_select,
  input wire logic reset_out_n,
  // design outputs
  input wire logic [BOOT_PORT_W-1:0] boot_config_port_pull,
  input wire logic boot_pull_en,
  input wire logic core_reset,
  input wire logic hold_cancel,
  input wire logic flash_ready,
  input wire logic bus_oe,
  input wire logic io_oe,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // cycles with both pins asking for reset
  logic [4:0] low_cnt_reg;
  always_ff @(posedge clk_sys)
    if (rst || reset_in_n || reset_mode_select) low_cnt_reg <= 5'h00;
    else if (low_cnt_reg != 5'h1F) low_cnt_reg <= low_cnt_reg + 5'h01;
  property p_enter;
    low_cnt_reg >= 5'h12 |-> !reset_out_n;
  endproperty
  a_enter: assert property (p_enter) else $error("no reset entry");
  property p_spike;
    $fell(reset_out_n) |-> $past(reset_in_n, 10) == 1'b0;
  endproperty
  a_spike: assert property (p_spike) else $error("short pulse taken");
  property p_ext;
    $rose(reset_out_n) |-> $past(reset_in_n, 3);
  endproperty
  a_ext: assert property (p_ext) else $error("early release");
  property p_flash;
    $rose(reset_out_n) && !external_boot_select |-> flash_ready;
  endproperty
  a_flash: assert property (p_flash) else $error("release before flash");
  property p_out;
    core_reset |-> !reset_out_n;
  endproperty
  a_out: assert property (p_out) else $error("reset out high");
  property p_float;
    core_reset |-> !bus_oe && !io_oe && boot_pull_en && &boot_config_port_pull;
  endproperty
  a_float: assert property (p_float) else $error("pins driven");
  property p_cancel;
    hold_cancel |-> core_reset;
  endproperty
  a_cancel: assert property (p_cancel) else $error("cancel outside reset");
  property p_strobe;
    !ale && rd_n && wr_n;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe active");
  c_ext: cover property ($rose(reset_out_n) && external_boot_select);
  c_int: cover property ($rose(reset_out_n) && !external_boot_select);
  c_enter: cover property ($fell(reset_out_n));
endmodule : arsq_props

bind arsq_top arsq_props i_props (.clk_sys(clk_sys), .rst(rst), .reset_in_n(reset_in_n),
  .reset_mode_select(reset_mode_select), .external_boot_select(external_boot_select),
  .reset_out_n(reset_out_n), .boot_config_port_pull(boot_config_port_pull),
  .boot_pull_en(boot_pull_en), .core_reset(core_reset), .hold_cancel(hold_cancel),
  .flash_ready(flash_ready), .bus_oe(bus_oe), .io_oe(io_oe), .ale(ale), .rd_n(rd_n),
  .wr_n(wr_n));

// ### tb/arsq_sup.sv
// model of the external reset supervisor
`timescale 1ns/1ps
module arsq_sup
  import arsq_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // reset and boot pins
  output logic reset_in_n,
  output logic reset_mode_select,
  output logic external_boot_select,
  output logic [BOOT_PORT_W-1:0] boot_config_port_in
);
  // power-on: both pins low, port settled
  initial
  begin
    reset_in_n = 1'b0;
    reset_mode_select = 1'b0;
    external_boot_select = 1'b1;
    boot_config_port_in = 16'hA5C3;
  end
  // boot source and port value
  task automatic set_boot(input logic ext, input logic [BOOT_PORT_W-1:0] cfg);
    @(posedge clk_sys);
    external_boot_select <= ext;
    boot_config_port_in <= cfg;
  endtask : set_boot
  // reset low for n cycles, then mode back high
  task automatic pulse(input int n, input logic mode);
    @(posedge clk_sys);
    reset_in_n <= 1'b0;
    reset_mode_select <= mode;
    repeat (n) @(posedge clk_sys);
    reset_in_n <= 1'b1;
    reset_mode_select <= 1'b1;
  endtask : pulse
  // reset low with mode high, mode falls after m cycles, release n cycles later
  task automatic late_mode(input int m, input int n);
    @(posedge clk_sys);
    reset_in_n <= 1'b0;
    reset_mode_select <= 1'b1;
    repeat (m) @(posedge clk_sys);
    reset_mode_select <= 1'b0;
    repeat (n) @(posedge clk_sys);
    reset_in_n <= 1'b1;
    reset_mode_select <= 1'b1;
  endtask : late_mode
endmodule : arsq_sup

// ### tb/tb_async_reset_sequencer.sv
// bench for the asynchronous reset sequencer
`timescale 1ns/1ps
module tb_async_reset_sequencer;
  import arsq_pkg::*;
  // shortened flash initialisation
  localparam int FL = 50;
  logic clk_sys, rst, hold_req, bus_busy, flash_read;
  wire logic reset_in_n, reset_mode_select, external_boot_select;
  wire logic [BOOT_PORT_W-1:0] boot_config_port_in;
  logic reset_out_n, boot_pull_en, core_reset, hold_cancel, bus_abort, flash_ready;
  logic bus_oe, io_oe, ale, rd_n, wr_n;
  logic [BOOT_PORT_W-1:0] pull, boot_config;
  logic [ADDR_W-1:0] start_addr;
  logic [7:0] start_segment;
  logic [DATA_W-1:0] flash_rdata;
  int n_fail = 0;
  int total_checks = 0;
  // clock
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  arsq_sup i_sup (.clk_sys(clk_sys), .reset_in_n(reset_in_n),
    .reset_mode_select(reset_mode_select), .external_boot_select(external_boot_select),
    .boot_config_port_in(boot_config_port_in));
  arsq_top #(.FLASH_CYCLES(FL), .EXT_WAIT(EXT_CYCLES)) i_dut (.clk_sys(clk_sys), .rst(rst),
    .reset_in_n(reset_in_n), .reset_mode_select(reset_mode_select),
    .external_boot_select(external_boot_select), .reset_out_n(reset_out_n),
    .boot_config_port_in(boot_config_port_in), .boot_config_port_pull(pull),
    .boot_pull_en(boot_pull_en), .boot_config(boot_config), .hold_req(hold_req),
    .bus_busy(bus_busy), .core_reset(core_reset), .hold_cancel(hold_cancel),
    .bus_abort(bus_abort), .start_addr(start_addr), .start_segment(start_segment),
    .flash_read(flash_read), .flash_rdata(flash_rdata), .flash_ready(flash_ready),
    .bus_oe(bus_oe), .io_oe(io_oe), .ale(ale), .rd_n(rd_n), .wr_n(wr_n));
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // cycles until reset_out_n reaches v, bounded
  task automatic wait_out(input logic v, input int lim, output int n);
    n = 0;
    while (reset_out_n !== v && n < lim)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask : wait_out
  // power-on hold then external boot
  task automatic t_power;
    int n;
    repeat (3) @(posedge clk_sys);
    #1;
    chk({reset_out_n, bus_oe, io_oe, boot_pull_en}, 4'h1);
    chk(pull, 16'hFFFF);
    chk({hold_cancel, bus_abort}, 2'h3);
    i_sup.pulse(4, 1'b0); // scaled power-on hold
    wait_out(1'b1, 40, n);
    chk(n >= 3 && n <= EXT_CYCLES + 6, 1'b1);
    chk(boot_config, 16'hA5C3);
    chk({bus_oe, core_reset, hold_cancel, bus_abort, ale, rd_n, wr_n}, 7'h43);
    chk({io_oe, boot_pull_en, reset_out_n}, 3'h5);
    chk({start_segment, start_addr}, 32'h0);
    @(posedge clk_sys);
    flash_read <= 1'b1;
    @(posedge clk_sys);
    flash_read <= 1'b0;
    #1;
    chk(flash_rdata, 16'h009B);
  endtask : t_power
  // spike and mode-high request ignored
  task automatic t_ignore;
    int n;
    i_sup.pulse(2, 1'b0); // below accept time
    wait_out(1'b0, 25, n);
    chk(n, 25);
    i_sup.pulse(30, 1'b1);
    wait_out(1'b0, 25, n);
    chk(n, 25);
  endtask : t_ignore
  // mode pin falls while reset-in held, external boot
  task automatic t_late;
    int n;
    i_sup.late_mode(20, 4);
    hold_req <= 1'b0;
    #1;
    chk(reset_out_n, 1'b0);
    @(posedge clk_sys);
    hold_req <= 1'b1;
    #1;
    chk({hold_cancel, bus_abort}, 2'h1);
    wait_out(1'b1, 40, n);
    chk(n >= 3 && n <= EXT_CYCLES + 6, 1'b1);
  endtask : t_late
  // accepted pulse, internal flash boot
  task automatic t_int;
    int n;
    i_sup.set_boot(1'b0, 16'h5A3C);
    i_sup.pulse(11, 1'b0); // just over accept time, no flash access in flight
    repeat (3) @(posedge clk_sys);
    flash_read <= 1'b1;
    #1;
    chk(reset_out_n, 1'b0);
    @(posedge clk_sys);
    #1;
    chk({flash_ready, flash_rdata}, 17'h0FFFF); // first flash cycle
    @(posedge clk_sys);
    #1;
    chk({flash_ready, flash_rdata}, 17'h0009B);
    wait_out(1'b1, 200, n);
    chk(n + 8 >= FL, 1'b1);
    chk({flash_ready, boot_config}, 17'h15A3C);
  endtask : t_int
  // verdict
  task automatic results;
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results
  // main sequence
  initial
  begin
    rst = 1'b1;
    hold_req = 1'b1;
    bus_busy = 1'b1;
    flash_read = 1'b0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_power;
    t_ignore;
    t_late;
    t_int;
    results;
  end
  // watchdog
  initial
  begin
    #50000;
    n_fail++;
    results;
  end
endmodule : tb_async_reset_sequencer
